// File: rtl/tbu_regs.svh
// Field positions, encodings and register offsets of the transmit buffer unpacker.
// Assumes includers are SystemVerilog design and testbench files of this block only.
`ifndef TBU_REGS_SVH
`define TBU_REGS_SVH

// ************************************************
// Buffer command word
// ************************************************
`define TBU_A_SIZE_HI   10
`define TBU_A_SIZE_LO   0
`define TBU_A_LS        12
`define TBU_A_FS        13
`define TBU_A_OFF_HI    20
`define TBU_A_OFF_LO    16
`define TBU_A_ALN_HI    25
`define TBU_A_ALN_LO    24
`define TBU_ALN_4       2'h0
`define TBU_ALN_16      2'h1
`define TBU_ALN_32      2'h2
`define TBU_MASK_4      13'h0003
`define TBU_MASK_16     13'h000F
`define TBU_MASK_32     13'h001F

// ************************************************
// Packet command word and status word
// ************************************************
`define TBU_B_LEN_HI    10
`define TBU_B_NOPAD     12
`define TBU_B_NOCRC     13
`define TBU_B_TAG_HI    31
`define TBU_B_TAG_LO    16
`define TBU_ST_ERR      15

// ************************************************
// Host controller registers (AHB-Lite byte offsets)
// ************************************************
`define TBU_REG_WORD    8'h00
`define TBU_REG_STAT    8'h04
`define TBU_REG_CNT     8'h08

`endif

// File: rtl/tbu_pkg.sv
// Types shared by both ends of the transmit buffer unpacker.
// Assumes tbu_regs.svh is included by the modules that need numbers.
package tbu_pkg;

    typedef enum logic [2:0] {
        DS_CMD_A,
        DS_CMD_B,
        DS_SKIP,
        DS_DATA,
        DS_PAD
    } tbu_dstate_t;

    typedef struct packed {
        tbu_dstate_t st;
        logic [31:0] cmd_a;
        logic [31:0] cmd_b;
        logic        first_w;
        logic        pkt_bad;
        logic [2:0]  skip;
        logic [9:0]  pad;
        logic [10:0] rem;
        logic [15:0] acc;
        logic        ready;
        logic        err;
        logic [31:0] mac_data;
        logic [3:0]  mac_be;
        logic        mac_valid;
        logic        mac_sop;
        logic        mac_eop;
        logic        mac_crc_add;
        logic        mac_pad_en;
        logic [31:0] txs_word;
        logic        txs_valid;
    } tbu_dev_t;

    typedef struct packed {
        logic        pend;
        logic [31:0] word;
        logic        act;
        logic        wr;
        logic [7:0]  addr;
        logic        hready;
        logic [31:0] hrdata;
        logic        hresp;
        logic [15:0] sent;
    } tbu_host_t;

endpackage : tbu_pkg

// File: rtl/tbu_link_if.sv
// Word link carrying host-written transmit buffers into the unpacker.
// Assumes both ends run on the same core_clk.
`timescale 1ns/1ps
interface tbu_link_if;
    logic        tx_valid;
    logic        tx_ready;
    logic [31:0] tx_word;

    modport dev  (input tx_valid, input tx_word, output tx_ready);
    modport host (output tx_valid, output tx_word, input tx_ready);
endinterface : tbu_link_if

// File: rtl/tbu_len_calc.sv
// Works out leading skip and trailing padding in whole words for one buffer.
// Assumes a stable buffer command word at its input; purely combinational.
`timescale 1ns/1ps
`include "tbu_regs.svh"
module tbu_len_calc
    import tbu_pkg::*;
(
    // Buffer command word
    input  wire logic [31:0] cmd_a,
    // Word counts
    output logic      [2:0]  skip_dw,
    output logic      [9:0]  pad_dw
);
    logic [10:0] size;
    logic [4:0]  off;
    logic [12:0] mask;
    logic [12:0] span;
    logic [12:0] rnd;
    logic [10:0] data_dw;
    logic [10:0] total_dw;

    always_comb begin
        size = cmd_a[`TBU_A_SIZE_HI:`TBU_A_SIZE_LO];
        off  = cmd_a[`TBU_A_OFF_HI:`TBU_A_OFF_LO];
        case (cmd_a[`TBU_A_ALN_HI:`TBU_A_ALN_LO])
            `TBU_ALN_16: mask = `TBU_MASK_16;
            `TBU_ALN_32: mask = `TBU_MASK_32;
            default:     mask = `TBU_MASK_4;
        endcase
        span     = {2'h0, size} + {8'h00, off};
        rnd      = (span + mask) & ~mask;
        total_dw = rnd[12:2];
        if (size == 11'h000) begin
            data_dw = 11'h000;
        end else begin
            data_dw = 11'(({2'h0, size} + {11'h000, off[1:0]} + 13'h0003) >> 2);
        end
        skip_dw = off[4:2];
        // Whatever trails the data up to the aligned end is padding
        pad_dw  = 10'(total_dw - data_dw - {8'h00, off[4:2]});
    end
endmodule : tbu_len_calc

// File: rtl/tbu_dev.sv
// Device end: unpacks host transmit buffers into payload words for the MAC buffer.
// Assumes the MAC transmit buffer accepts a word every cycle and holds the packet
// until its end marker before sending (store-and-forward).
//
// How it works
// - size field counts payload bytes only
// - size, offset and alignment give trailing pad words
// - summed sizes must match packet length
// - packet tag copied into status word
// - bit 13 set suppresses automatic CRC unless bit 12 set
// - bit 12 set suppresses padding, keeps CRC
// - host writes total packet length field
// - host writes reserved bits as zero
// - data starts at third word of buffer
// - offset low bits pick first byte lane
// - offset high bits skip whole words
// - unused trailing bytes never forwarded
// - host pads buffer to chosen alignment
// - alignment padding is discarded
// - middle buffers hold at least four bytes
// - MAC buffer sends only whole packets
// - host limits packet space to 2036 bytes
// - host may cap packets at 86 buffers
// - skipped and padding words never stored
// - bits 13/12 mark first/last buffer
// - error flag never halts transmission
// - differing packet command words raise error
`timescale 1ns/1ps
`include "tbu_regs.svh"
module tbu_dev
    import tbu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Buffer link from the host
    tbu_link_if.dev          lk,
    // MAC transmit buffer side
    output logic      [31:0] mac_data,
    output logic      [3:0]  mac_be,
    output logic             mac_valid,
    output logic             mac_sop,
    output logic             mac_eop,
    output logic             mac_crc_add,
    output logic             mac_pad_en,
    // Transmit status
    output logic      [31:0] txs_word,
    output logic             txs_valid,
    // Error flag to software
    output logic             tx_error_flag,
    input  wire logic        err_clr
);
    // ************************************************
    // State and helpers
    // ************************************************
    tbu_dev_t    s_r;
    tbu_dev_t    s_nxt;
    logic        take;
    logic        fin;
    logic        len_bad;
    logic        b_bad;
    logic [2:0]  skip_dw;
    logic [9:0]  pad_dw;
    logic [10:0] size;
    logic [1:0]  lo;
    logic [2:0]  room;
    logic [2:0]  cnt;
    logic [3:0]  lane_be;
    tbu_dstate_t after_data;
    tbu_dstate_t after_skip;

    tbu_len_calc tbu_len_calc_inst (
        .cmd_a   (s_r.cmd_a),
        .skip_dw (skip_dw),
        .pad_dw  (pad_dw)
    );

    assign size = s_r.cmd_a[`TBU_A_SIZE_HI:`TBU_A_SIZE_LO];
    // Only the first data word of a buffer starts mid-word
    assign lo   = s_r.first_w ? s_r.cmd_a[`TBU_A_OFF_LO+1:`TBU_A_OFF_LO] : 2'h0;
    assign room = 3'h4 - {1'b0, lo};
    assign cnt  = ({8'h00, room} > s_r.rem) ? s_r.rem[2:0] : room;

    // ************************************************
    // Byte lanes carrying payload in this word
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            // Lanes past the last payload byte are dropped here
            assign lane_be[gi] = (3'(gi) >= {1'b0, lo}) &&
                                 (3'(gi) < ({1'b0, lo} + cnt));
        end
    endgenerate

    // ************************************************
    // Unpacking sequence
    // ************************************************
    always_comb begin
        s_nxt           = s_r;
        s_nxt.mac_valid = 1'b0;
        s_nxt.mac_sop   = 1'b0;
        s_nxt.mac_eop   = 1'b0;
        s_nxt.txs_valid = 1'b0;
        s_nxt.ready     = 1'b1;
        take            = lk.tx_valid && s_r.ready;
        b_bad           = 1'b0;
        after_data      = (pad_dw != 10'h000) ? DS_PAD : DS_CMD_A;
        after_skip      = (size != 11'h000) ? DS_DATA : after_data;
        case (s_r.st)
            DS_CMD_A: begin
                if (take) begin
                    s_nxt.cmd_a = lk.tx_word;
                    s_nxt.st    = DS_CMD_B;
                end
            end
            DS_CMD_B: begin
                if (take) begin
                    // Payload begins after this word and any skipped offset words
                    s_nxt.cmd_b   = lk.tx_word;
                    s_nxt.skip    = skip_dw;
                    s_nxt.pad     = pad_dw;
                    s_nxt.rem     = size;
                    s_nxt.first_w = 1'b1;
                    if (s_r.cmd_a[`TBU_A_FS]) begin
                        s_nxt.acc     = {5'h00, size};
                        s_nxt.pkt_bad = 1'b0;
                    end else begin
                        s_nxt.acc = s_r.acc + {5'h00, size};
                        b_bad     = lk.tx_word != s_r.cmd_b;
                        s_nxt.pkt_bad = s_r.pkt_bad || b_bad;
                    end
                    // Whole leading offset words never reach the MAC buffer
                    s_nxt.st = (skip_dw != 3'h0) ? DS_SKIP : after_skip;
                end
            end
            DS_SKIP: begin
                if (take) begin
                    s_nxt.skip = s_r.skip - 3'h1;
                    if (s_r.skip == 3'h1) begin
                        s_nxt.st = after_skip;
                    end
                end
            end
            DS_DATA: begin
                if (take) begin
                    s_nxt.mac_data    = lk.tx_word;
                    s_nxt.mac_be      = lane_be;
                    s_nxt.mac_valid   = 1'b1;
                    s_nxt.mac_sop     = s_r.first_w && s_r.cmd_a[`TBU_A_FS];
                    s_nxt.mac_crc_add = !s_r.cmd_b[`TBU_B_NOCRC] ||
                                        s_r.cmd_b[`TBU_B_NOPAD];
                    s_nxt.mac_pad_en  = !s_r.cmd_b[`TBU_B_NOPAD];
                    s_nxt.first_w     = 1'b0;
                    s_nxt.rem         = s_r.rem - {8'h00, cnt};
                    if (s_r.rem == {8'h00, cnt}) begin
                        s_nxt.st = after_data;
                    end
                end
            end
            DS_PAD: begin
                if (take) begin
                    // Padding words are swallowed without output
                    s_nxt.pad = s_r.pad - 10'h001;
                    if (s_r.pad == 10'h001) begin
                        s_nxt.st = DS_CMD_A;
                    end
                end
            end
            default: begin
                s_nxt.st = DS_CMD_A;
            end
        endcase

        // Buffer ends when the sequence leaves its payload part
        fin = take && (s_r.st != DS_CMD_A) && (s_r.st != DS_PAD) &&
              ((s_nxt.st == DS_PAD) || (s_nxt.st == DS_CMD_A));
        len_bad = s_nxt.acc != {5'h00, s_nxt.cmd_b[`TBU_B_LEN_HI:0]};

        // Clear first, so an error in the same cycle still sets the flag
        if (err_clr) begin
            s_nxt.err = 1'b0;
        end
        if (b_bad) begin
            s_nxt.err = 1'b1;
        end
        if (fin && s_r.cmd_a[`TBU_A_LS]) begin
            // End marker lets the MAC buffer release the stored packet
            s_nxt.mac_eop   = 1'b1;
            s_nxt.txs_valid = 1'b1;
            s_nxt.txs_word  = '0;
            s_nxt.txs_word[`TBU_B_TAG_HI:`TBU_B_TAG_LO] =
                s_nxt.cmd_b[`TBU_B_TAG_HI:`TBU_B_TAG_LO];
            s_nxt.txs_word[`TBU_ST_ERR] = len_bad || s_nxt.pkt_bad;
            if (len_bad) begin
                s_nxt.err = 1'b1;
            end
        end
        // The link keeps flowing whatever the error flag shows
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_r    <= '0;
            s_r.st <= DS_CMD_A;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign lk.tx_ready   = s_r.ready;
    assign mac_data      = s_r.mac_data;
    assign mac_be        = s_r.mac_be;
    assign mac_valid     = s_r.mac_valid;
    assign mac_sop       = s_r.mac_sop;
    assign mac_eop       = s_r.mac_eop;
    assign mac_crc_add   = s_r.mac_crc_add;
    assign mac_pad_en    = s_r.mac_pad_en;
    assign txs_word      = s_r.txs_word;
    assign txs_valid     = s_r.txs_valid;
    assign tx_error_flag = s_r.err;
endmodule : tbu_dev

// File: rtl/tbu_host.sv
// Host end: AHB-Lite slave whose word register feeds buffer words onto the link.
// Assumes software builds each buffer (commands, offset, payload, padding) itself.
`timescale 1ns/1ps
`include "tbu_regs.svh"
module tbu_host
    import tbu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Buffer link to the device
    tbu_link_if.host         lk
);
    tbu_host_t s_r;
    tbu_host_t s_nxt;
    logic      addr_ph;

    // ************************************************
    // Bus slave and link feeder
    // ************************************************
    always_comb begin
        s_nxt   = s_r;
        addr_ph = hsel && hready && htrans[1];
        if (s_r.pend && lk.tx_ready) begin
            s_nxt.pend = 1'b0;
            s_nxt.sent = s_r.sent + 16'h0001;
        end
        // A stalled write resumes once the previous word has left
        if (!s_r.hready && !s_r.pend) begin
            s_nxt.hready = 1'b1;
        end
        if (s_r.act && s_r.hready) begin
            s_nxt.act = 1'b0;
            // Software owns buffer layout and length fields
            if (s_r.wr && s_r.addr == `TBU_REG_WORD) begin
                s_nxt.word = hwdata;
                s_nxt.pend = 1'b1;
            end
        end
        if (addr_ph) begin
            s_nxt.act    = 1'b1;
            s_nxt.wr     = hwrite;
            s_nxt.addr   = haddr[7:0];
            s_nxt.hrdata = '0;
            // One word buffered: a second write waits, limiting nothing else
            if (hwrite && haddr[7:0] == `TBU_REG_WORD && s_nxt.pend) begin
                s_nxt.hready = 1'b0;
            end
            if (!hwrite) begin
                case (haddr[7:0])
                    `TBU_REG_STAT: s_nxt.hrdata = {31'h0, s_r.pend};
                    `TBU_REG_CNT:  s_nxt.hrdata = {16'h0000, s_r.sent};
                    default:       s_nxt.hrdata = '0;
                endcase
            end
        end
        s_nxt.hresp = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_r        <= '0;
            s_r.hready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout   = s_r.hready;
    assign hrdata      = s_r.hrdata;
    assign hresp       = s_r.hresp;
    assign lk.tx_valid = s_r.pend;
    assign lk.tx_word  = s_r.word;
endmodule : tbu_host

// File: verif/tbu_chk.sv
// Checker for the link and MAC side of the transmit buffer unpacker.
// Assumes one core_clk domain and srst synchronous, active high.
`timescale 1ns/1ps
module tbu_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Link
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [31:0] tx_word,
    // MAC side and status
    input wire logic [31:0] mac_data,
    input wire logic [3:0]  mac_be,
    input wire logic        mac_valid,
    input wire logic        mac_sop,
    input wire logic        mac_eop,
    input wire logic        mac_crc_add,
    input wire logic        mac_pad_en,
    input wire logic [31:0] txs_word,
    input wire logic        txs_valid,
    input wire logic        tx_error_flag,
    input wire logic        err_clr
);
    logic [31:0] be_mask;
    assign be_mask = {{8{mac_be[3]}}, {8{mac_be[2]}}, {8{mac_be[1]}}, {8{mac_be[0]}}};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ****************************************
    // Link handshake
    // ****************************************
    sequence s_stalled; tx_valid && !tx_ready; endsequence
    sequence s_held; tx_valid && $stable(tx_word); endsequence
    property p_hold; s_stalled |=> s_held; endproperty
    a_hold: assert property (p_hold) else $error("link word dropped while stalled");
    property p_ready; !$past(srst) |-> tx_ready; endproperty
    a_ready: assert property (p_ready) else $error("link not ready after reset");

    // ****************************************
    // Payload path
    // ****************************************
    property p_take; mac_valid |-> $past(tx_valid && tx_ready); endproperty
    a_take: assert property (p_take) else $error("payload without accepted word");
    property p_lane; mac_valid |-> ((mac_data ^ $past(tx_word)) & be_mask) == 32'h0; endproperty
    a_lane: assert property (p_lane) else $error("payload lanes differ from link word");
    property p_sop; mac_sop |-> mac_valid && mac_be != 4'h0; endproperty
    a_sop: assert property (p_sop) else $error("start marker without payload");
    property p_crc; mac_valid && !mac_pad_en |-> mac_crc_add; endproperty
    a_crc: assert property (p_crc) else $error("crc dropped with padding off");

    // ****************************************
    // Status and error flag
    // ****************************************
    property p_status; 1'b1 |-> txs_valid == mac_eop; endproperty
    a_status: assert property (p_status) else $error("status not with end marker");
    property p_txs_rsv; txs_valid |-> txs_word[14:0] == 15'h0; endproperty
    a_txs_rsv: assert property (p_txs_rsv) else $error("status low bits not zero");
    property p_err_rep; txs_valid && txs_word[15] |-> ##[0:1] tx_error_flag; endproperty
    a_err_rep: assert property (p_err_rep) else $error("packet error without flag");
    property p_sticky; tx_error_flag && !err_clr |=> tx_error_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("error flag cleared by itself");
endmodule : tbu_chk

// File: verif/tx_buffer_command_unpacker_tb_top.sv
// Testbench: software writes buffers over AHB-Lite, payload is read at the MAC side.
// Assumes the host and device ends meet through tbu_link_if on one clock.
`timescale 1ns/1ps
`include "tbu_regs.svh"
module tx_buffer_command_unpacker_tb_top;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0;
    logic        err_clr  = 1'b0;
    logic        hreadyout, hresp, mac_valid, mac_sop, mac_eop, mac_crc_add, mac_pad_en;
    logic        txs_valid, tx_error_flag, crc_seen, pad_seen;
    logic [31:0] hrdata, mac_data, txs_word, txs_seen, rd;
    logic [3:0]  mac_be;
    logic [7:0]  exp_q[$];
    logic [7:0]  got_q[$];
    int          errors, cmp_count, sop_n, eop_n, eop_exp, words_sent;

    always #4 core_clk = ~core_clk;

    tbu_link_if tbu_link_if_inst ();
    tbu_host tbu_host_inst (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lk(tbu_link_if_inst));
    tbu_dev tbu_dev_inst (.core_clk(core_clk), .srst(srst), .lk(tbu_link_if_inst),
        .mac_data(mac_data), .mac_be(mac_be), .mac_valid(mac_valid), .mac_sop(mac_sop),
        .mac_eop(mac_eop), .mac_crc_add(mac_crc_add), .mac_pad_en(mac_pad_en),
        .txs_word(txs_word), .txs_valid(txs_valid), .tx_error_flag(tx_error_flag),
        .err_clr(err_clr));
    tbu_chk tbu_chk_inst (.core_clk(core_clk), .srst(srst),
        .tx_valid(tbu_link_if_inst.tx_valid), .tx_ready(tbu_link_if_inst.tx_ready),
        .tx_word(tbu_link_if_inst.tx_word), .mac_data(mac_data), .mac_be(mac_be),
        .mac_valid(mac_valid), .mac_sop(mac_sop), .mac_eop(mac_eop),
        .mac_crc_add(mac_crc_add), .mac_pad_en(mac_pad_en), .txs_word(txs_word),
        .txs_valid(txs_valid), .tx_error_flag(tx_error_flag), .err_clr(err_clr));

    // ****************************************
    // MAC side monitor
    // ****************************************
    always @(posedge core_clk) begin
        if (mac_valid === 1'b1) begin
            for (int i = 0; i < 4; i++)
                if (mac_be[i]) got_q.push_back(mac_data[8*i +: 8]);
            crc_seen = mac_crc_add;
            pad_seen = mac_pad_en;
        end
        if (mac_sop === 1'b1) sop_n++;
        if (txs_valid === 1'b1) begin
            eop_n++;
            txs_seen = txs_word;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("Comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // One single transfer; hready of the only slave is its hreadyout
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic put_word(input logic [31:0] w);
        ahb_xfer(1'b1, `TBU_REG_WORD, w);
        words_sent++;
    endtask : put_word

    function automatic logic [31:0] mk_b(logic [15:0] tag, logic nocrc, nopad,
                                         logic [10:0] len);
        return {tag, 2'h0, nocrc, nopad, 1'b0, len};
    endfunction : mk_b

    // Offset and padding bytes carry junk so that leaks show up in the payload
    task automatic send_buf(input logic fs, ls, input logic [4:0] off,
                            input logic [10:0] size, input logic [1:0] aln,
                            input logic [31:0] cmdb, input logic [7:0] seed);
        int          al;
        int          n;
        logic [31:0] w;
        al = (aln == 2'h1) ? 16 : (aln == 2'h2) ? 32 : 4;
        n = ((off + size + al - 1) / al) * al;
        w = 32'h0;
        put_word({6'h0, aln, 3'h0, off, 2'h0, fs, ls, 1'b0, size});
        put_word(cmdb);
        for (int k = 0; k < n; k++) begin
            if (k >= off && k < off + size) begin
                w[8*(k%4) +: 8] = seed + 8'(k - off);
                exp_q.push_back(seed + 8'(k - off));
            end else begin
                w[8*(k%4) +: 8] = 8'hEE;
            end
            if (k % 4 == 3) put_word(w);
        end
    endtask : send_buf

    task automatic wait_eop;
        int t;
        eop_exp++;
        t = 0;
        while (eop_n != eop_exp && t < 200) begin
            @(negedge core_clk);
            t++;
        end
        check("eop count", eop_n, eop_exp);
        check("sop count", sop_n, eop_exp);
        // Realign to the rising edge so the next bus request starts there
        @(posedge core_clk);
    endtask : wait_eop

    task automatic end_pkt(input logic [15:0] tag, input logic err, crc, pad);
        wait_eop();
        check("byte count", got_q.size(), exp_q.size());
        foreach (exp_q[i]) check("payload byte", got_q[i], exp_q[i]);
        check("status word", txs_seen, {tag, err, 15'h0});
        check("crc add", crc_seen, crc);
        check("pad enable", pad_seen, pad);
        exp_q.delete();
        got_q.delete();
    endtask : end_pkt

    task automatic one_pkt(input logic [4:0] off, input logic [10:0] size,
                           input logic [1:0] aln, input logic nocrc, nopad,
                           input logic [15:0] tag);
        send_buf(1'b1, 1'b1, off, size, aln, mk_b(tag, nocrc, nopad, size), tag[7:0]);
        end_pkt(tag, 1'b0, !nocrc || nopad, !nopad);
    endtask : one_pkt

    task automatic pulse_clr;
        err_clr <= 1'b1;
        @(posedge core_clk);
        err_clr <= 1'b0;
        @(negedge core_clk);
        check("flag cleared", tx_error_flag, 1'b0);
        @(posedge core_clk);
    endtask : pulse_clr

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_multi;
        logic [31:0] b;
        b = mk_b(16'h5A3C, 1'b0, 1'b0, 11'h06F);
        send_buf(1'b1, 1'b0, 5'h07, 11'h04F, 2'h1, b, 8'h10);
        send_buf(1'b0, 1'b0, 5'h00, 11'h00F, 2'h1, b, 8'h60);
        send_buf(1'b0, 1'b1, 5'h0A, 11'h011, 2'h1, b, 8'h80);
        end_pkt(16'h5A3C, 1'b0, 1'b1, 1'b1);
        check("flag after good packet", tx_error_flag, 1'b0);
    endtask : t_multi

    task automatic t_modes;
        one_pkt(5'h02, 11'h0B7, 2'h0, 1'b0, 1'b0, 16'h1101);
        one_pkt(5'h1F, 11'h001, 2'h2, 1'b1, 1'b0, 16'h2202);
        one_pkt(5'h03, 11'h040, 2'h1, 1'b1, 1'b1, 16'h3303);
        one_pkt(5'h00, 11'h004, 2'h0, 1'b0, 1'b1, 16'h4404);
    endtask : t_modes

    task automatic t_len_err;
        send_buf(1'b1, 1'b1, 5'h01, 11'h00A, 2'h0, mk_b(16'h7707, 1'b0, 1'b0, 11'h00B), 8'h30);
        end_pkt(16'h7707, 1'b1, 1'b1, 1'b1);
        check("flag on length error", tx_error_flag, 1'b1);
        one_pkt(5'h06, 11'h015, 2'h1, 1'b0, 1'b0, 16'h8808);
        check("flag held", tx_error_flag, 1'b1);
        pulse_clr();
    endtask : t_len_err

    task automatic t_cmdb_diff;
        send_buf(1'b1, 1'b0, 5'h00, 11'h008, 2'h0, mk_b(16'h0001, 1'b0, 1'b0, 11'h010), 8'h40);
        send_buf(1'b0, 1'b1, 5'h00, 11'h008, 2'h0, mk_b(16'h0002, 1'b0, 1'b0, 11'h010), 8'h48);
        wait_eop();
        check("flag on command mismatch", tx_error_flag, 1'b1);
        check("status error bit", txs_seen[15], 1'b1);
        exp_q.delete();
        got_q.delete();
        pulse_clr();
    endtask : t_cmdb_diff

    task automatic t_regs;
        logic [31:0] cnt;
        ahb_xfer(1'b0, `TBU_REG_STAT, 32'h0);
        check("pending flag", rd, 32'h0);
        ahb_xfer(1'b1, 8'h10, 32'hDEADBEEF);
        ahb_xfer(1'b0, 8'h0C, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("bus response", hresp, 1'b0);
        cnt = {16'h0, 16'(words_sent)};
        ahb_xfer(1'b0, `TBU_REG_CNT, 32'h0);
        check("word count", rd, cnt);
    endtask : t_regs

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_multi();
        t_modes();
        t_len_err();
        t_cmdb_diff();
        t_regs();
        wrap_up();
    end

    // Whole run needs a few hundred cycles; this leaves a wide margin
    initial begin
        repeat (30000) @(posedge core_clk);
        errors++;
        wrap_up();
    end
endmodule : tx_buffer_command_unpacker_tb_top
